// ==== logic/wakeup_timebase.sv ====
/*
 * Timebase select, RC trim calibration and false wakeup counter with an AXI4-Lite slave.
 * Assumes serial clock and chip select arrive asynchronously on pins; wakeup events
 * come from same-clock logic as one-cycle pulses.
 */
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps
module wakeup_timebase
	import wakeup_timebase_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic freq_detect_pass,
	input wire logic pattern_match_fail,
	input wire logic xtal_clk,
	input wire logic rc_clk,
	input wire logic serial_clk_pin,
	input wire logic chip_select_pin,
	output logic rtc_clk,
	output logic timebase_source_sel,
	output logic xtal_osc_enable,
	output logic [15:0] rc_trim,
	output logic irq
);
	ctrl_t ctrl;
	cal_state_t cal_state;
	logic [7:0] false_count;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;
	logic trim_valid;
	logic [6:0] edge_count;
	logic [15:0] period_count;
	logic [3:0] sync_a, sync_b, sync_c, pin_level;
	logic sclk_level, cs_level, sclk_prev, xtal_level, rc_level;
	logic sclk_rise;
	logic false_event, cal_done;
	logic have_aw, have_w;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic do_write;

	// Three-stage synchronisers for all four foreign pins, oscillators included, since none shares aclk
	// A level changes only once stages two and three agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_a <= 4'h0;
			sync_b <= 4'h0;
			sync_c <= 4'h0;
			pin_level <= 4'h0;
			sclk_prev <= 1'b0;
		end else begin
			sync_a <= {rc_clk, xtal_clk, chip_select_pin, serial_clk_pin};
			sync_b <= sync_a;
			sync_c <= sync_b;
			pin_level <= (sync_b & sync_c) | (pin_level & (sync_b | sync_c));
			sclk_prev <= sclk_level;
		end
	end
	assign {rc_level, xtal_level, cs_level, sclk_level} = pin_level;
	assign sclk_rise = sclk_level && !sclk_prev;

	assign false_event = freq_detect_pass && pattern_match_fail && !ctrl.manch_en;

	// False wakeup counter saturates so software never sees a wrap to a quiet value
	always_ff @(posedge aclk) begin
		if (!aresetn)
			false_count <= false_count_reset;
		else if (false_event && false_count != 8'hFF)
			false_count <= false_count + 8'h01;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rtc_clk <= 1'b0;
			timebase_source_sel <= 1'b0;
			xtal_osc_enable <= 1'b0;
		end else begin
			timebase_source_sel <= ctrl.timebase_source_sel;
			xtal_osc_enable <= ctrl.xtal_osc_enable;
			rtc_clk <= ctrl.timebase_source_sel ? xtal_level : rc_level;
		end
	end

	// gated edge counting
	// Edges only count in the counting state, entered with select high after the command
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cal_state <= cal_idle;
			edge_count <= 7'h00;
		end else begin
			unique case (cal_state)
				cal_idle: begin
					edge_count <= 7'h00;
					if (do_write && aw_addr == ctrl_offset && w_data[ctrl_trim_cmd_bit] && w_strb[0] && cs_level)
						cal_state <= cal_counting;
				end
				cal_armed: cal_state <= cal_counting;
				cal_counting: begin
					if (!cs_level)
						cal_state <= cal_idle; // Select dropped early: abandon
					else if (sclk_rise) begin
						edge_count <= edge_count + 7'h01;
						if (edge_count + 7'h01 == cal_edge_count)
							cal_state <= cal_idle;
					end
				end
			endcase
		end
	end
	assign cal_done = cal_state == cal_counting && cs_level && sclk_rise && edge_count + 7'h01 == cal_edge_count;

	// Reference period measured in aclk cycles becomes the trim word
	always_ff @(posedge aclk) begin
		if (!aresetn)
			period_count <= 16'h0000;
		else if (cal_state != cal_counting)
			period_count <= 16'h0000;
		else if (period_count != 16'hFFFF)
			period_count <= period_count + 16'h0001;
	end

	// trim lost on RC off or reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rc_trim <= trim_reset_value;
			trim_valid <= 1'b0;
		end else if (cal_done) begin
			rc_trim <= period_count;
			trim_valid <= 1'b1;
		end else if (!ctrl.rc_on) begin
			rc_trim <= trim_reset_value;
			trim_valid <= 1'b0;
		end
	end

	// AXI write capture: address and data may arrive in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			have_aw <= 1'b0;
			have_w <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= resp_okay;
		end else begin
			s_axi_awready <= !have_aw && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready <= !have_w && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				have_aw <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				have_w <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				have_aw <= 1'b0;
				have_w <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr > irq_mask_offset || aw_addr[1:0] != 2'h0) ? resp_slverr : resp_okay;
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end
	assign do_write = have_aw && have_w && !s_axi_bvalid;

	// Software registers; trim command bit is self-clearing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= ctrl_t'(ctrl_reset_value);
			irq_mask <= irq_mask_reset;
		end else begin
			ctrl.trim_cmd <= 1'b0;
			if (do_write && w_strb[0]) begin
				if (aw_addr == ctrl_offset)
					ctrl <= ctrl_t'(w_data[4:0]);
				if (aw_addr == irq_mask_offset)
					irq_mask <= w_data[1:0];
			end
		end
	end

	// Sticky interrupt bits: a new event wins over a write-one clear
	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq_status <= 2'h0;
		else
			irq_status <= (irq_status & ~((do_write && w_strb[0] && aw_addr == irq_status_offset) ? w_data[1:0] : 2'h0))
				| {cal_done, false_event};
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			irq <= 1'b0;
		else
			irq <= |(irq_status & irq_mask);
	end

	// AXI read path, one read at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= resp_okay;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= resp_okay;
				unique case (s_axi_araddr)
					ctrl_offset: s_axi_rdata <= {27'h0, ctrl};
					false_count_offset: s_axi_rdata <= {24'h0, false_count};
					trim_offset: s_axi_rdata <= {16'h0, rc_trim};
					status_offset: s_axi_rdata <= {29'h0, ctrl.timebase_source_sel, trim_valid, cal_state != cal_idle};
					irq_status_offset: s_axi_rdata <= {30'h0, irq_status};
					irq_mask_offset: s_axi_rdata <= {30'h0, irq_mask};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= resp_slverr;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	a_false_count_inc: assert property (@(posedge aclk) disable iff (!aresetn)
		false_event && false_count != 8'hFF |=> false_count == $past(false_count) + 8'h01)
		else $error("false wakeup count did not step");
	a_manch_blocks_count: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl.manch_en && !(do_write && aw_addr == ctrl_offset) |=> $stable(false_count))
		else $error("false wakeups counted with Manchester on");
	a_source_select_mux: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 timebase_source_sel |-> rtc_clk == $past(xtal_level))
		else $error("timebase not from crystal");
	a_trim_after_edges: assert property (@(posedge aclk) disable iff (!aresetn)
		cal_done |=> trim_valid && rc_trim == $past(period_count))
		else $error("trim not applied at final edge");
	a_trim_lost_off: assert property (@(posedge aclk) disable iff (!aresetn)
		!ctrl.rc_on && !cal_done |=> !trim_valid)
		else $error("trim kept with RC off");
	a_edges_need_select: assert property (@(posedge aclk) disable iff (!aresetn)
		!cs_level |=> $stable(edge_count) || edge_count == 7'h00)
		else $error("edge counted without select");
	a_count_bounded: assert property (@(posedge aclk) disable iff (!aresetn)
		edge_count <= cal_edge_count)
		else $error("edge count passed limit");
	a_irq_follows_mask: assert property (@(posedge aclk) disable iff (!aresetn)
		|(irq_status & irq_mask) |=> irq)
		else $error("interrupt missing");

	c_false_seen: cover property (@(posedge aclk) disable iff (!aresetn) false_event);
	c_cal_finished: cover property (@(posedge aclk) disable iff (!aresetn) cal_done);
	c_cal_aborted: cover property (@(posedge aclk) disable iff (!aresetn) cal_state == cal_counting ##1 cal_state == cal_idle && !trim_valid);
endmodule : wakeup_timebase

// ==== logic/wakeup_timebase_pkg.sv ====
/*
 * Constants and carrier types for the wakeup timebase and false wakeup counter block.
 * Assumes a 125 MHz aclk and AXI4-Lite register access from software.
 */
package wakeup_timebase_pkg;
	// Register byte offsets
	localparam logic [7:0] ctrl_offset = 8'h00;
	localparam logic [7:0] false_count_offset = 8'h04;
	localparam logic [7:0] trim_offset = 8'h08;
	localparam logic [7:0] status_offset = 8'h0C;
	localparam logic [7:0] irq_status_offset = 8'h10;
	localparam logic [7:0] irq_mask_offset = 8'h14;
	// Control register fields
	localparam int ctrl_src_sel_bit = 0;
	localparam int ctrl_xtal_en_bit = 1;
	localparam int ctrl_manch_en_bit = 2;
	localparam int ctrl_rc_on_bit = 3;
	localparam int ctrl_trim_cmd_bit = 4;
	localparam logic [4:0] ctrl_reset_value = 5'h08;
	// Status register fields
	localparam int status_cal_busy_bit = 0;
	localparam int status_trim_valid_bit = 1;
	localparam int status_src_bit = 2;
	// Interrupt bits
	localparam int irq_false_bit = 0;
	localparam int irq_cal_done_bit = 1;
	localparam logic [1:0] irq_mask_reset = 2'h0;
	// Calibration
	localparam logic [6:0] cal_edge_count = 7'h41; // 65 reference edges
	localparam logic [7:0] false_count_reset = 8'h00;
	localparam logic [15:0] trim_reset_value = 16'h0000;
	// AXI responses
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;

	typedef struct packed {
		logic trim_cmd;
		logic rc_on;
		logic manch_en;
		logic xtal_osc_enable;
		logic timebase_source_sel;
	} ctrl_t;

	typedef enum logic [1:0] {cal_idle, cal_armed, cal_counting} cal_state_t;
endpackage : wakeup_timebase_pkg

// ==== tb/host_link_model.sv ====
/*
 * Behavioural controller side of the calibration link: chip select and reference clock.
 * Assumes the bench asks for a frame with cs_req and starts the edges with run.
 */
`timescale 1ns/100ps
module host_link_model (
	input wire logic cs_req,
	input wire logic run,
	input wire logic [7:0] n_edges,
	output logic serial_clk_pin,
	output logic chip_select_pin,
	output logic done
);
	// One frame; clock stands low between frames, every pin change 5 ns after an aclk rising edge
	initial begin
		serial_clk_pin = 1'b0;
		chip_select_pin = 1'b0;
		done = 1'b0;
		forever begin
			wait (cs_req);
			#5 chip_select_pin = 1'b1;
			wait (run);
			// Start off the aclk edge so no pin change races the sampling clock
			#5;
			// fixed-period reference edges, repeated per request
			repeat (n_edges) begin
				#32 serial_clk_pin = 1'b1;
				#32 serial_clk_pin = 1'b0;
			end
			#40 chip_select_pin = 1'b0;
			done = 1'b1;
			wait (!cs_req);
			done = 1'b0;
		end
	end
endmodule : host_link_model

// ==== tb/wakeup_timebase_tb.sv ====
/*
 * Self-checking bench: AXI4-Lite master tasks, wakeup pulses and calibration frames.
 * Assumes the controller model in host_link_model and the package constants.
 */
`timescale 1ns/100ps
module wakeup_timebase_tb;
	import wakeup_timebase_pkg::*;
	typedef struct packed {logic [7:0] a; logic [31:0] d; logic [1:0] r;} row_t;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, fdp, pmf, xtal_clk, rc_clk, rtc_clk;
	logic sclk, cs, sel, xen, irq, cs_req, run, done;
	logic [7:0] awaddr, araddr, n_edges;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs, br;
	logic [15:0] rc_trim, trim_a;
	int failures = 0;
	int cmp_count = 0;
	int cycles = 0;
	// Reset values and address decode, unmapped and misaligned last
	row_t rows [8] = '{'{ctrl_offset, 32'h0000_0008, resp_okay}, '{false_count_offset, 32'h0000_0000, resp_okay},
		'{trim_offset, 32'h0000_0000, resp_okay}, '{status_offset, 32'h0000_0000, resp_okay},
		'{irq_status_offset, 32'h0000_0000, resp_okay}, '{irq_mask_offset, 32'h0000_0000, resp_okay},
		'{8'h18, 32'h0000_0000, resp_slverr}, '{8'h05, 32'h0000_0000, resp_slverr}};

	wakeup_timebase dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .freq_detect_pass(fdp),
		.pattern_match_fail(pmf), .xtal_clk(xtal_clk), .rc_clk(rc_clk), .serial_clk_pin(sclk),
		.chip_select_pin(cs), .rtc_clk(rtc_clk), .timebase_source_sel(sel), .xtal_osc_enable(xen),
		.rc_trim(rc_trim), .irq(irq));
	host_link_model host (.cs_req(cs_req), .run(run), .n_edges(n_edges), .serial_clk_pin(sclk),
		.chip_select_pin(cs), .done(done));

	// Clock at 125 MHz
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	// Hang guard, ceiling well above the longest run
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		if (failures == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	task automatic check(input logic [33:0] got, input logic [33:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : check

	// Address and data offered together, each released when taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready === 1'b1) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge aclk);
		br = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge aclk);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	// Both flags held n cycles; each cycle with both high is one event while Manchester is off
	task automatic pulse(input logic f, input logic p, input int n);
		@(posedge aclk);
		fdp <= f;
		pmf <= p;
		repeat (n) @(posedge aclk);
		fdp <= 1'b0;
		pmf <= 1'b0;
	endtask : pulse

	// Select, command, n reference edges, deselect; settle for the synchroniser
	task automatic cal(input logic [7:0] n);
		int i;
		i = 0;
		n_edges <= n;
		cs_req <= 1'b1;
		repeat (10) @(posedge aclk);
		axi_wr(ctrl_offset, 32'h0000_0018);
		run <= 1'b1;
		while (done !== 1'b1 && i < 2000) begin
			@(posedge aclk);
			i++;
		end
		if (done !== 1'b1) begin
			failures++;
			$display("BAD %0t calibration frame never ended", $time);
		end
		cs_req <= 1'b0;
		run <= 1'b0;
		repeat (10) @(posedge aclk);
	endtask : cal

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, fdp, pmf, cs_req, run} = '0;
		{awaddr, araddr, n_edges, wdata} = '0;
		wstrb = 4'hf;
		// external clock static high; channel modes lie outside this block
		xtal_clk = 1'b1;
		rc_clk = 1'b0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		foreach (rows[i]) begin
			axi_rd(rows[i].a, rd, rs);
			check({rs, rd}, {rows[i].r, rows[i].d});
		end
		axi_wr(8'h18, 32'h0000_0001);
		check({32'h0, br}, {32'h0, resp_slverr});
		axi_wr(ctrl_offset, 32'h0000_000B);
		check({32'h0, br}, {32'h0, resp_okay});
		repeat (3) @(posedge aclk);
		check({31'h0, xen, sel, rtc_clk}, 34'h7);
		axi_wr(ctrl_offset, 32'h0000_0008);
		repeat (3) @(posedge aclk);
		check({31'h0, xen, sel, rtc_clk}, 34'h0);
		pulse(1'b1, 1'b1, 3);
		pulse(1'b1, 1'b0, 2);
		pulse(1'b0, 1'b1, 2);
		axi_rd(false_count_offset, rd, rs);
		check({rs, rd}, 34'h3);
		check({33'h0, irq}, 34'h0);
		axi_wr(irq_mask_offset, 32'h0000_0001);
		repeat (2) @(posedge aclk);
		check({33'h0, irq}, 34'h1);
		axi_wr(irq_status_offset, 32'h0000_0001);
		repeat (2) @(posedge aclk);
		check({33'h0, irq}, 34'h0);
		axi_wr(ctrl_offset, 32'h0000_000C);
		pulse(1'b1, 1'b1, 4);
		axi_rd(false_count_offset, rd, rs);
		check({rs, rd}, 34'h3);
		axi_wr(ctrl_offset, 32'h0000_0008);
		cal(8'd64);
		axi_rd(status_offset, rd, rs);
		check({rs, rd}, 34'h0);
		cal(8'd65);
		axi_rd(status_offset, rd, rs);
		check({rs, rd}, 34'h2);
		check({33'h0, rc_trim != 16'h0000}, 34'h1);
		trim_a = rc_trim;
		axi_rd(irq_status_offset, rd, rs);
		check({rs, rd}, 34'h2);
		// Command with select low must not restart counting
		axi_wr(ctrl_offset, 32'h0000_0018);
		repeat (8) @(posedge aclk);
		axi_rd(status_offset, rd, rs);
		check({rs, rd}, 34'h2);
		// Extra edges after the 65th must not move the trim
		cal(8'd70);
		check({18'h0, rc_trim}, {18'h0, trim_a});
		axi_wr(ctrl_offset, 32'h0000_0000);
		repeat (2) @(posedge aclk);
		axi_rd(status_offset, rd, rs);
		check({rs, rd}, 34'h0);
		check({18'h0, rc_trim}, 34'h0);
		// Recalibrate, then a reset after the frame has ended must drop the fresh trim
		cal(8'd65);
		check({18'h0, rc_trim}, {18'h0, trim_a});
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		check({18'h0, rc_trim}, 34'h0);
		axi_rd(status_offset, rd, rs);
		check({rs, rd}, 34'h0);
		axi_rd(ctrl_offset, rd, rs);
		check({rs, rd}, 34'h8);
		end_of_test();
	end
endmodule : wakeup_timebase_tb
